// ==== core/ssr_host.sv ====
// host sequencer driving a strobed 1k x 1 static ram with chip selects
`timescale 1ns/1ps
module ssr_host (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ssr_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_rdata,
    output logic latch_pulse_n,
    output logic chip_sel_a_n,
    output logic chip_sel_b_n,
    output logic write_en_n,
    output logic [ssr_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_din,
    input wire logic mem_dout
);
    ssr_pkg::ssr_state_t state;
    ssr_pkg::ssr_state_t next_state;
    logic [ssr_pkg::CNT_W-1:0] cnt;
    logic [ssr_pkg::CNT_W-1:0] next_cnt;
    logic is_write;
    logic next_is_write;
    logic next_req_ready;
    logic next_rsp_valid;
    logic next_rsp_rdata;
    logic next_latch_pulse_n;
    logic next_sel_n;
    logic next_write_en_n;
    logic [ssr_pkg::ADDR_W-1:0] next_mem_addr;
    logic next_mem_din;
    logic dout_sync;

    // ----------------------------------------------------------------
    // read data input
    // ----------------------------------------------------------------
    // device output is asynchronous to ref_clk
    ssr_pin_sync u_dout_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(mem_dout),
        .q(dout_sync)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // next state, counter and registered pin levels
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_is_write = is_write;
        next_rsp_valid = 1'h0;
        next_rsp_rdata = rsp_rdata;
        next_mem_addr = mem_addr;
        next_mem_din = mem_din;
        unique case (state)
            ssr_pkg::SSR_IDLE: begin
                if (req_valid) begin
                    // address and data settle before strobe falls
                    next_mem_addr = req_addr; // see RULE12
                    next_mem_din = req_wdata;
                    next_is_write = req_write;
                    next_cnt = ssr_pkg::SETUP_LD;
                    next_state = ssr_pkg::SSR_SETUP; // see RULE7
                end
            end
            ssr_pkg::SSR_SETUP: begin
                if (cnt == ssr_pkg::CNT_RST) begin
                    next_cnt = ssr_pkg::HOLD_LD;
                    next_state = ssr_pkg::SSR_LATCH;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ssr_pkg::SSR_LATCH: begin
                // selects stay high until address hold has passed
                if (cnt != ssr_pkg::CNT_RST) begin
                    next_cnt = cnt - 4'h1;
                end else if (is_write) begin
                    next_cnt = ssr_pkg::WR_LD;
                    next_state = ssr_pkg::SSR_WRITE; // see RULE11
                end else begin
                    next_cnt = ssr_pkg::RD_LD;
                    next_state = ssr_pkg::SSR_READ; // see RULE11
                end
            end
            ssr_pkg::SSR_WRITE: begin
                if (cnt == ssr_pkg::CNT_RST) begin
                    next_state = ssr_pkg::SSR_WR_END;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ssr_pkg::SSR_WR_END: begin
                // write enable rose first; now release the rest
                next_cnt = ssr_pkg::REC_LD;
                next_state = ssr_pkg::SSR_RECOVER;
            end
            ssr_pkg::SSR_READ: begin
                if (cnt == ssr_pkg::CNT_RST) begin
                    next_rsp_rdata = dout_sync;
                    next_cnt = ssr_pkg::REC_LD;
                    next_state = ssr_pkg::SSR_RECOVER;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ssr_pkg::SSR_RECOVER: begin
                if (cnt == ssr_pkg::CNT_RST) begin
                    next_rsp_valid = 1'h1;
                    next_state = ssr_pkg::SSR_IDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_cnt = ssr_pkg::CNT_RST;
                next_state = ssr_pkg::SSR_IDLE;
            end
        endcase
    end

    // pin levels follow the next state so outputs come from flops
    always_comb begin
        next_req_ready = (next_state == ssr_pkg::SSR_IDLE);
        // strobe low from latch through end of access
        next_latch_pulse_n = !(next_state == ssr_pkg::SSR_LATCH ||
            next_state == ssr_pkg::SSR_WRITE ||
            next_state == ssr_pkg::SSR_WR_END ||
            next_state == ssr_pkg::SSR_READ); // see RULE7
        // active low selects, high in every idle phase
        next_sel_n = !(next_state == ssr_pkg::SSR_WRITE ||
            next_state == ssr_pkg::SSR_WR_END ||
            next_state == ssr_pkg::SSR_READ); // see RULE9
        // write only while strobe and both selects are low
        next_write_en_n = !(next_state == ssr_pkg::SSR_WRITE); // see RULE3
    end

    // register state and pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ssr_pkg::SSR_IDLE;
            cnt <= ssr_pkg::CNT_RST;
            is_write <= 1'h0;
            req_ready <= 1'h1;
            rsp_valid <= 1'h0;
            rsp_rdata <= 1'h0;
            latch_pulse_n <= 1'h1;
            chip_sel_a_n <= 1'h1;
            chip_sel_b_n <= 1'h1;
            write_en_n <= 1'h1;
            mem_addr <= ssr_pkg::ADDR_RST;
            mem_din <= 1'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            is_write <= next_is_write;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            latch_pulse_n <= next_latch_pulse_n;
            chip_sel_a_n <= next_sel_n;
            chip_sel_b_n <= next_sel_n;
            write_en_n <= next_write_en_n;
            mem_addr <= next_mem_addr;
            mem_din <= next_mem_din;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_strobe_fall;
        $fell(latch_pulse_n);
    endsequence

    sequence s_addr_held;
        $stable(mem_addr) [*3];
    endsequence

    sequence s_we_low;
        !write_en_n [*4];
    endsequence

    // write enable low only with strobe and both selects low
    a_write_all_low: assert property ( // see RULE3
        !write_en_n |-> (!latch_pulse_n && !chip_sel_a_n &&
            !chip_sel_b_n))
        else $error("write enable low without strobe and selects");

    // write pulse lasts four cycles then rises before the selects
    a_write_pulse_len: assert property ( // see RULE3
        $fell(write_en_n) |-> s_we_low ##1 (write_en_n &&
            !chip_sel_a_n && !latch_pulse_n))
        else $error("write pulse length or end order wrong");

    // address stable across the strobe fall and its hold time
    a_addr_at_fall: assert property ( // see RULE7
        s_strobe_fall |-> $stable(mem_addr) ##0 s_addr_held)
        else $error("address moved around strobe fall");

    // selects fall two cycles after the strobe, never before
    a_sel_after_hold: assert property ( // see RULE11
        $fell(chip_sel_a_n) |-> !$past(latch_pulse_n, 2) &&
            $past(chip_sel_a_n, 1))
        else $error("chip select fell before address hold");

    // both selects move together and idle high
    a_sel_idle_high: assert property ( // see RULE9
        req_ready |-> (chip_sel_a_n && chip_sel_b_n && write_en_n &&
            latch_pulse_n && chip_sel_a_n == chip_sel_b_n))
        else $error("control pins not idle high while ready");

    // strobe stays high for the recovery time
    a_strobe_recover: assert property ( // see RULE9
        $rose(latch_pulse_n) |-> latch_pulse_n [*4])
        else $error("strobe high time too short");

    // request accepted in ready leads to a strobe fall two cycles on
    a_req_to_strobe: assert property ( // see RULE7
        (req_valid && req_ready) |=> !req_ready ##1 $fell(latch_pulse_n))
        else $error("strobe did not follow accepted request");

    // response is a one-cycle pulse and ready returns with it
    a_rsp_pulse: assert property ( // see RULE12
        rsp_valid |-> req_ready ##1 !rsp_valid)
        else $error("response pulse malformed");

endmodule

// ==== core/ssr_pin_sync.sv ====
// three-stage synchroniser for a pin input with agreement filter
`timescale 1ns/1ps
module ssr_pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    output logic q
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_q;

    // ----------------------------------------------------------------
    // filter
    // ----------------------------------------------------------------
    // a change counts only once the second and third stages agree
    always_comb begin
        next_q = q;
        if (stage2 == stage3) begin
            next_q = stage3;
        end
    end

    // stage1 is read by stage2 only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'h0;
            stage2 <= 1'h0;
            stage3 <= 1'h0;
            q <= 1'h0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            q <= next_q;
        end
    end
endmodule

// ==== include/ssr_pkg.sv ====
// constants and types for the strobed static ram host controller
// Summary of operation
// RULE1 - device drives data only while strobe low
// RULE2 - chip-select device holds read bit after strobe
// RULE3 - write needs strobe, selects, write enable low
// RULE4 - first rising control edge ends the write
// RULE5 - simple device floats output on hold or write
// RULE6 - select high or write floats the output
// RULE7 - address captured at strobe fall, host holds valid
// RULE8 - array holds 1024 one-bit words
// RULE9 - write enable and selects are active low
// RULE10 - simple device acts as selects tied to strobe
// RULE11 - host may share lines, selects separate phases
// RULE12 - ten-bit address register held between strobes
package ssr_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int WORDS = 1024;
    localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;

    // ----------------------------------------------------------------
    // clock and pin timing in nanoseconds
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_ACCESS_NS = 600;
    localparam int T_ENABLE_NS = 375;
    localparam int T_DISABLE_NS = 375;
    localparam int T_STR_HIGH_NS = 395;
    localparam int T_STR_LOW_NS = 600;
    localparam int T_WRITE_NS = 395;
    localparam int T_ADDR_SETUP_NS = 20;
    localparam int T_ADDR_HOLD_NS = 170;
    localparam int T_DATA_SETUP_NS = 395;

    // least times round up, never below one cycle
    function automatic int ceil_cyc(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ----------------------------------------------------------------
    // derived cycle counts
    // ----------------------------------------------------------------
    localparam int SYNC_LAT = 3;
    localparam int SETUP_CYC = ceil_cyc(T_ADDR_SETUP_NS);
    localparam int HOLD_CYC = ceil_cyc(T_ADDR_HOLD_NS);
    localparam int WR_CYC = max2(max2(ceil_cyc(T_WRITE_NS),
        ceil_cyc(T_DATA_SETUP_NS)), ceil_cyc(T_STR_LOW_NS) - HOLD_CYC);
    // the agreement filter needs one more sample than its three stages
    localparam int RD_CYC = max2(ceil_cyc(T_ACCESS_NS) - HOLD_CYC,
        ceil_cyc(T_ENABLE_NS)) + SYNC_LAT + 1;
    localparam int REC_CYC = max2(ceil_cyc(T_STR_HIGH_NS),
        ceil_cyc(T_DISABLE_NS));

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] WR_LD = CNT_W'(WR_CYC - 1);
    localparam logic [CNT_W-1:0] RD_LD = CNT_W'(RD_CYC - 1);
    localparam logic [CNT_W-1:0] REC_LD = CNT_W'(REC_CYC - 1);

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SSR_IDLE = 3'h0,
        SSR_SETUP = 3'h1,
        SSR_LATCH = 3'h2,
        SSR_WRITE = 3'h3,
        SSR_WR_END = 3'h4,
        SSR_READ = 3'h5,
        SSR_RECOVER = 3'h6
    } ssr_state_t;

endpackage

// ==== testbench/ssr_sram_model.sv ====
// behavioural 1k x 1 strobed static ram with two chip selects
`timescale 1ns/1ps
module ssr_sram_model #(
    parameter int ACC_NS = 590,
    parameter bit SIMPLE = 1'b0
) (
    input wire logic latch_pulse_n,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b_n,
    input wire logic write_en_n,
    input wire logic [9:0] mem_addr,
    input wire logic mem_din,
    output logic mem_dout
);
    logic mem [0:1023];
    logic [9:0] addr_reg;
    logic out_lat;
    logic drive;
    logic sel_a_eff;
    logic sel_b_eff;
    // the simple device acts as if both selects were tied to the strobe
    assign sel_a_eff = SIMPLE ? latch_pulse_n : chip_sel_a_n;
    assign sel_b_eff = SIMPLE ? latch_pulse_n : chip_sel_b_n;
    // array starts cleared so the bench can predict unwritten words
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 1'b0;
        end
        addr_reg = 10'h000;
        out_lat = 1'b0;
    end
    // address register loads on strobe fall, held until the next one
    always @(negedge latch_pulse_n) begin
        addr_reg = mem_addr;
    end
    // write lasts only while all four controls are low
    always @* begin
        if (!latch_pulse_n && !sel_a_eff && !sel_b_eff && !write_en_n) begin
            mem[addr_reg] = mem_din;
        end
    end
    // read bit appears late in the access window and then stays latched
    always @(negedge latch_pulse_n) begin
        #(ACC_NS);
        if (!latch_pulse_n && write_en_n) begin
            out_lat = mem[addr_reg];
        end
    end
    // floated output shows the inverse so stale data cannot pass
    // simple device: drives only with strobe low, floats on hold or write
    assign drive = !sel_a_eff && !sel_b_eff && write_en_n;
    assign mem_dout = drive ? out_lat : ~out_lat;
endmodule

// ==== testbench/strobed_static_ram_1kx1_tb.sv ====
// self-checking bench for the strobed static ram host sequencer
`timescale 1ns/1ps
module strobed_static_ram_1kx1_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [9:0] req_addr = 10'h000;
    logic req_wdata = 1'b0;
    logic req_ready, rsp_valid, rsp_rdata, latch_pulse_n;
    logic chip_sel_a_n, chip_sel_b_n, write_en_n, mem_din, mem_dout;
    logic [9:0] mem_addr;
    logic mem_dout_s;
    logic [9:0] exp_addr = 10'h000;
    logic exp_din = 1'b0;
    logic prev_rsp = 1'b0;
    logic ref_mem [0:1023];
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'h1377;
    // ----------------------------------------------------------------
    // clock, design and far-side model
    // ----------------------------------------------------------------
    always #50 ref_clk = ~ref_clk;
    ssr_host dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .latch_pulse_n(latch_pulse_n),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_n(chip_sel_b_n),
        .write_en_n(write_en_n), .mem_addr(mem_addr), .mem_din(mem_din),
        .mem_dout(mem_dout));
    ssr_sram_model ram (.latch_pulse_n(latch_pulse_n),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_n(chip_sel_b_n),
        .write_en_n(write_en_n), .mem_addr(mem_addr), .mem_din(mem_din),
        .mem_dout(mem_dout));
    // simple device on the same pins, its output watched only
    ssr_sram_model #(.SIMPLE(1'b1)) ram_s (.latch_pulse_n(latch_pulse_n),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_n(chip_sel_b_n),
        .write_en_n(write_en_n), .mem_addr(mem_addr), .mem_din(mem_din),
        .mem_dout(mem_dout_s));
    // ----------------------------------------------------------------
    // comparison and closing
    // ----------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // pin monitors
    // ----------------------------------------------------------------
    // address must be valid when the strobe falls
    always @(negedge latch_pulse_n) begin
        if (!rst) check(mem_addr === exp_addr, "address at strobe fall");
    end
    // write enable only inside a full strobe and select window
    always @(negedge ref_clk) begin
        if (!rst && write_en_n === 1'b0) begin
            check(!latch_pulse_n && !chip_sel_a_n && !chip_sel_b_n, "write outside window");
            check(mem_din === exp_din, "write data pin");
        end
        if (!rst) check(chip_sel_a_n === chip_sel_b_n, "selects differ");
        // both devices float on hold and agree once the selects are low
        if (!rst && (latch_pulse_n || !chip_sel_a_n)) begin
            check(mem_dout_s === mem_dout, "simple output");
        end
        // simple device drives on strobe alone, chip-select one floats
        if (!rst && !latch_pulse_n && chip_sel_a_n && write_en_n) begin
            check(mem_dout_s === ~mem_dout, "simple drive");
        end
        if (!rst) check(!(rsp_valid && prev_rsp), "response longer than one cycle");
        prev_rsp = rsp_valid;
    end
    // ----------------------------------------------------------------
    // one request, waits for its answer and compares read data
    // ----------------------------------------------------------------
    task automatic do_req(input logic wr, input logic [9:0] a, input logic d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        check(req_ready === 1'b1, "ready timeout");
        exp_addr = a;
        exp_din = wr ? d : exp_din;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge ref_clk);
        req_valid = 1'b0;
        req_addr = ~a;
        req_wdata = ~d;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            check(req_ready === 1'b0, "ready while busy");
            @(negedge ref_clk);
            n++;
        end
        check(rsp_valid === 1'b1, "no response");
        check(latch_pulse_n && chip_sel_a_n && write_en_n, "pins not idle");
        if (wr) begin
            ref_mem[a] = d;
        end else begin
            check(rsp_rdata === ref_mem[a], "read data");
        end
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 1024; i++) begin
            ref_mem[i] = 1'b0;
        end
        repeat (10) @(negedge ref_clk);
        check(req_ready === 1'b1 && latch_pulse_n === 1'b1, "reset state");
        rst = 1'b0;
        @(negedge ref_clk);
        do_req(1'b1, 10'h000, 1'b1);
        do_req(1'b1, 10'h3FF, 1'b1);
        do_req(1'b0, 10'h000, 1'b0);
        do_req(1'b0, 10'h001, 1'b1);
        do_req(1'b0, 10'h3FF, 1'b0);
        do_req(1'b1, 10'h3FF, 1'b0);
        do_req(1'b0, 10'h3FF, 1'b1);
        for (int k = 0; k < 300; k++) begin
            do_req(1'($random(seed)), 10'($random(seed) % 16), 1'($random(seed)));
        end
        tally_and_finish();
    end
    initial begin
        #(100 * 20000);
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
